// ===== rtl/ttc_top.sv
// trigger time capture: fine and coarse trigger stamping with record start offset
`timescale 1ns/10ps
`include "ttc_cfg.svh"

// Summary of operation
// - front-panel trigger located to one 125 ps trigger-clock step
// - frame and backplane sources resolved only to one 4 ns data-clock period, soft triggers to one 8 ns block cycle
// - fine position given only for front-panel triggers
// - fine position forms the low bits of the record timestamp
// - first sample is the sample instant at or after the trigger
// - signed record start offset, positive when first sample follows trigger
// - configured delay or pretrigger is added to the record start offset
// - soft trigger command fires and stamps the block cycle it arrives in
// - rising or falling edge chosen apart for front-panel and frame inputs
// - frame and backplane inputs act as 4 ns resolution trigger sources
module ttc_top (
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire ttc_pkg::ttc_bus_t         bus,
    output logic [31:0]                    rdata,
    input  wire logic [`TTC_FP_W-1:0]      front_panel_trigger_input,
    input  wire logic [`TTC_CO_W-1:0]      frame_sync_input,
    input  wire logic [`TTC_CO_W-1:0]      backplane_star_trigger,
    input  wire logic [`TTC_CO_W-1:0]      backplane_mlvds_trigger,
    output ttc_pkg::ttc_event_t            front_panel_trigger_input_event,
    output logic                           armed
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        ttc_pkg::ttc_state_t     fsm;
        ttc_pkg::ttc_src_t       src;
        logic                    fp_fall;
        logic                    fs_fall;
        logic signed [31:0]      delay;
        logic [`TTC_CNT_W-1:0]   cnt;
        logic                    prev_fp;
        logic                    prev_fs;
        logic                    prev_star;
        logic                    prev_mlvds;
        logic                    captured;
        logic                    armed;
        logic [31:0]             rdata;
        ttc_pkg::ttc_event_t     evt;
    } ttc_regs_t;

    ttc_regs_t r;
    ttc_regs_t next_r;

    localparam int RsMinSteps = `TTC_RS_MIN_NS * 1000 / `TTC_FRONT_PANEL_TRIGGER_INPUT_CLK_PS;
    localparam int RsMaxSteps = `TTC_RS_MAX_NS * 1000 / `TTC_FRONT_PANEL_TRIGGER_INPUT_CLK_PS;
    localparam int SampleMax  = `TTC_SAMPLE_STEPS - 1;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // front-panel fine edge search
    // ------------------------------------------------------------------
    logic                    fp_hit;
    logic [`TTC_FINE_W-1:0]  fp_idx;

    ttc_fine_edge u_fine (
        .sample_word (front_panel_trigger_input),
        .prev_bit    (r.prev_fp),
        .falling     (r.fp_fall),
        .edge_found  (fp_hit),
        .edge_index  (fp_idx)
    );

    // ------------------------------------------------------------------
    // coarse sources: earliest data-clock slot with an edge
    // ------------------------------------------------------------------
    function automatic logic [1:0] coarse_edge(input logic [1:0] w, input logic prev);
        logic e0;
        logic e1;
        e0 = w[0] & ~prev;
        e1 = w[1] & ~w[0];
        coarse_edge = {e0 | e1, ~e0};
    endfunction

    logic [1:0] fs_e;
    logic [1:0] star_e;
    logic [1:0] mlvds_e;

    assign fs_e    = coarse_edge(frame_sync_input ^ {`TTC_CO_W{r.fs_fall}},
                                 r.prev_fs ^ r.fs_fall);
    assign star_e  = coarse_edge(backplane_star_trigger, r.prev_star);
    assign mlvds_e = coarse_edge(backplane_mlvds_trigger, r.prev_mlvds);

    // ------------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------------
    logic                    hw_hit;
    logic [`TTC_FINE_W-1:0]  hw_fine;

    always_comb begin
        hw_hit  = 1'b0;
        hw_fine = '0;
        case (r.src)
            ttc_pkg::TTC_SRC_FRONT: begin
                hw_hit  = fp_hit;
                hw_fine = fp_idx;
            end
            ttc_pkg::TTC_SRC_FRAME: begin
                hw_hit  = fs_e[1];
                hw_fine = {fs_e[0], `TTC_STEP_W'(0)};
            end
            ttc_pkg::TTC_SRC_STAR: begin
                hw_hit  = star_e[1];
                hw_fine = {star_e[0], `TTC_STEP_W'(0)};
            end
            ttc_pkg::TTC_SRC_MLVDS: begin
                hw_hit  = mlvds_e[1];
                hw_fine = {mlvds_e[0], `TTC_STEP_W'(0)};
            end
            default: begin
                hw_hit  = 1'b0;
                hw_fine = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic wr_cmd;
    logic is_armed;
    logic soft_cmd;
    logic fire;

    assign wr_cmd   = bus.wr && (bus.addr == `TTC_REG_CMD);
    assign is_armed = (r.fsm != ttc_pkg::TTC_DISARMED);
    assign soft_cmd = wr_cmd && bus.wdata[`TTC_CMD_SOFT];
    // a hardware edge beats a soft command in the same cycle: it carries fine time
    assign fire     = is_armed && (hw_hit || soft_cmd);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [`TTC_FINE_W-1:0] sel_fine;
        int                     fm;
        logic signed [31:0]     gap;
        next_r           = r;
        sel_fine         = '0;
        fm               = 0;
        gap              = '0;
        next_r.evt.pulse = 1'b0;
        next_r.rdata     = '0;
        next_r.cnt       = r.cnt + 1'b1;
        next_r.prev_fp    = front_panel_trigger_input[`TTC_FP_W-1];
        next_r.prev_fs    = frame_sync_input[`TTC_CO_W-1];
        next_r.prev_star  = backplane_star_trigger[`TTC_CO_W-1];
        next_r.prev_mlvds = backplane_mlvds_trigger[`TTC_CO_W-1];

        if (bus.wr && bus.addr == `TTC_REG_CFG) begin
            next_r.src     = ttc_pkg::ttc_src_t'(bus.wdata[`TTC_CFG_SRC_MSB:`TTC_CFG_SRC_LSB]);
            next_r.fp_fall = bus.wdata[`TTC_CFG_FP_FALL];
            next_r.fs_fall = bus.wdata[`TTC_CFG_FS_FALL];
        end
        if (bus.wr && bus.addr == `TTC_REG_DELAY) begin
            next_r.delay = signed'(bus.wdata);
        end

        case (r.fsm)
            ttc_pkg::TTC_DISARMED: begin
                if (wr_cmd && bus.wdata[`TTC_CMD_ARM]) begin
                    next_r.fsm = ttc_pkg::TTC_ARMED;
                end
            end
            ttc_pkg::TTC_ARMED: begin
                if (fire) begin
                    next_r.fsm = ttc_pkg::TTC_FIRED;
                end
            end
            ttc_pkg::TTC_FIRED: begin
                if (!fire) begin
                    next_r.fsm = ttc_pkg::TTC_ARMED;
                end
            end
            default: begin
                next_r.fsm = ttc_pkg::TTC_DISARMED;
            end
        endcase
        if (wr_cmd && bus.wdata[`TTC_CMD_DISARM]) begin
            next_r.fsm = ttc_pkg::TTC_DISARMED;
        end
        // registered copy so the armed pin comes straight from a flop
        next_r.armed = (next_r.fsm != ttc_pkg::TTC_DISARMED);

        if (wr_cmd && bus.wdata[`TTC_CMD_CLR]) begin
            next_r.captured = 1'b0;
        end
        if (fire) begin
            sel_fine = hw_hit ? hw_fine : '0;
            fm       = int'(sel_fine) % `TTC_SAMPLE_STEPS;
            // rounds up to the next sample, never to the nearest
            gap      = (fm == 0) ? 32'sd0 : 32'(`TTC_SAMPLE_STEPS - fm);
            next_r.captured       = 1'b1;
            next_r.evt.pulse      = 1'b1;
            next_r.evt.source     = hw_hit ? r.src : ttc_pkg::TTC_SRC_SOFT;
            next_r.evt.fine_valid = hw_hit && (r.src == ttc_pkg::TTC_SRC_FRONT);
            next_r.evt.ts         = {r.cnt, sel_fine};
            next_r.evt.rstart     = gap + r.delay;
        end

        if (bus.rd) begin
            case (bus.addr)
                `TTC_REG_CFG: begin
                    next_r.rdata[`TTC_CFG_SRC_MSB:`TTC_CFG_SRC_LSB] = r.src;
                    next_r.rdata[`TTC_CFG_FP_FALL] = r.fp_fall;
                    next_r.rdata[`TTC_CFG_FS_FALL] = r.fs_fall;
                end
                `TTC_REG_DELAY: begin
                    next_r.rdata = r.delay;
                end
                `TTC_REG_STATUS: begin
                    next_r.rdata[`TTC_ST_ARMED] = is_armed;
                    next_r.rdata[`TTC_ST_CAPT]  = r.captured;
                    next_r.rdata[`TTC_ST_SRC_MSB:`TTC_ST_SRC_LSB] = r.evt.source;
                end
                `TTC_REG_TS_LO: begin
                    next_r.rdata = r.evt.ts[31:0];
                end
                `TTC_REG_TS_HI: begin
                    next_r.rdata = 32'(r.evt.ts[`TTC_TS_W-1:32]);
                end
                `TTC_REG_RSTART: begin
                    next_r.rdata = r.evt.rstart;
                end
                default: begin
                    next_r.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rdata      = r.rdata;
    assign front_panel_trigger_input_event = r.evt;
    assign armed      = r.armed;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    fp_step_index_a: assert property (
        (is_armed && r.src == ttc_pkg::TTC_SRC_FRONT && fp_hit)
        |=> (r.evt.ts[`TTC_FINE_W-1:0] == $past(fp_idx)) && r.evt.fine_valid
    ) else $error("front-panel fine index not stamped");

    coarse_res_a: assert property (
        (r.evt.pulse && r.evt.source != ttc_pkg::TTC_SRC_FRONT)
        |-> (r.evt.ts[`TTC_STEP_W-1:0] == '0)
    ) else $error("coarse source carries sub-period bits");

    fine_only_fp_a: assert property (
        r.evt.pulse |-> (r.evt.fine_valid == (r.evt.source == ttc_pkg::TTC_SRC_FRONT))
    ) else $error("fine flag on wrong source");

    ts_embed_a: assert property (
        r.evt.pulse |-> (r.evt.ts[`TTC_TS_W-1:`TTC_FINE_W] == $past(r.cnt))
    ) else $error("timestamp not taken at trigger cycle");

    round_up_a: assert property (
        r.evt.pulse |-> ((r.evt.rstart - $past(r.delay)) >= 0)
                     && ((r.evt.rstart - $past(r.delay)) <= SampleMax)
                     && (((int'(r.evt.ts[`TTC_FINE_W-1:0]) + r.evt.rstart - $past(r.delay))
                          % `TTC_SAMPLE_STEPS) == 0)
    ) else $error("first sample not rounded up");

    rs_range_a: assert property (
        (r.evt.pulse && $past(r.delay) == 0)
        |-> (r.evt.rstart >= RsMinSteps) && (r.evt.rstart <= RsMaxSteps)
    ) else $error("record start outside undelayed range");

    delay_incl_a: assert property (
        (fire && !(bus.wr && bus.addr == `TTC_REG_DELAY) && r.delay > RsMaxSteps)
        |=> (r.evt.rstart > RsMaxSteps)
    ) else $error("delay missing from record start");

    soft_fire_a: assert property (
        (soft_cmd && is_armed && !hw_hit)
        |=> r.evt.pulse && (r.evt.source == ttc_pkg::TTC_SRC_SOFT)
            && (r.evt.ts[`TTC_TS_W-1:`TTC_FINE_W] == $past(r.cnt))
    ) else $error("soft trigger not stamped");

    disarm_quiet_a: assert property (
        (wr_cmd && bus.wdata[`TTC_CMD_DISARM]) |=> !armed ##1 !r.evt.pulse
    ) else $error("trigger accepted after disarm");

    frame_edge_a: assert property (
        (is_armed && r.src == ttc_pkg::TTC_SRC_FRAME
         && frame_sync_input[0] == !r.fs_fall && r.prev_fs == r.fs_fall)
        |=> r.evt.pulse && (r.evt.ts[`TTC_FINE_W-1:0] == '0)
    ) else $error("frame edge missed or misplaced");

    slot_index_a: assert property (
        (r.evt.pulse && r.evt.fine_valid)
        |-> (r.evt.ts[`TTC_FINE_W-1] == ($past(fp_idx) >= `TTC_STEPS_PER_DATA))
    ) else $error("data-period slot wrong");

    capt_sticky_a: assert property (
        (fire && wr_cmd && bus.wdata[`TTC_CMD_CLR]) |=> r.captured
    ) else $error("capture flag lost on clear");

    polarity_edge_a: assert property (
        (r.src == ttc_pkg::TTC_SRC_FRONT && fp_hit)
        |-> (front_panel_trigger_input[fp_idx] != r.fp_fall)
    ) else $error("front-panel edge has wrong polarity");

    rdata_idle_a: assert property (
        !bus.rd |=> (rdata == '0)
    ) else $error("read data outside read cycle");

    evt_hold_a: assert property (
        !fire |=> !r.evt.pulse && $stable(r.evt.ts) && $stable(r.evt.rstart)
    ) else $error("event fields changed without trigger");

    armed_out_a: assert property (
        armed == is_armed
    ) else $error("armed output out of step");

    fp_front_panel_trigger_input_c:    cover property (r.evt.pulse && r.evt.fine_valid);
    capt_keep_c:  cover property (fire && wr_cmd && bus.wdata[`TTC_CMD_CLR]);
    frame_front_panel_trigger_input_c: cover property (r.evt.pulse && r.evt.source == ttc_pkg::TTC_SRC_FRAME);
    soft_front_panel_trigger_input_c:  cover property (r.evt.pulse && r.evt.source == ttc_pkg::TTC_SRC_SOFT);
    delayed_c:    cover property (r.evt.pulse && r.evt.rstart < 0);

endmodule

// ===== rtl/ttc_cfg.svh
// constants for the trigger time capture block
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

// ------------------------------------------------------------------
// clocks and time steps
// ------------------------------------------------------------------
`define TTC_CLK_MHZ          125
`define TTC_FRONT_PANEL_TRIGGER_INPUT_CLK_PS      125
`define TTC_DATA_CLK_PS      4000
`define TTC_BLOCK_CLK_PS     (1000000 / `TTC_CLK_MHZ)
`define TTC_STEPS_PER_DATA   (`TTC_DATA_CLK_PS / `TTC_FRONT_PANEL_TRIGGER_INPUT_CLK_PS)
`define TTC_DATA_PER_BLOCK   (`TTC_BLOCK_CLK_PS / `TTC_DATA_CLK_PS)
`define TTC_FP_W             (`TTC_STEPS_PER_DATA * `TTC_DATA_PER_BLOCK)
`define TTC_CO_W             `TTC_DATA_PER_BLOCK
`define TTC_STEP_W           5
`define TTC_FINE_W           6
`define TTC_SAMPLE_STEPS     8
`define TTC_TS_W             48
`define TTC_CNT_W            (`TTC_TS_W - `TTC_FINE_W)
`define TTC_RS_MIN_NS        (-375)
`define TTC_RS_MAX_NS        500

// ------------------------------------------------------------------
// register map and fields
// ------------------------------------------------------------------
`define TTC_AW               8
`define TTC_REG_CMD          8'h00
`define TTC_REG_CFG          8'h04
`define TTC_REG_DELAY        8'h08
`define TTC_REG_STATUS       8'h0c
`define TTC_REG_TS_LO        8'h10
`define TTC_REG_TS_HI        8'h14
`define TTC_REG_RSTART       8'h18
`define TTC_CMD_ARM          0
`define TTC_CMD_DISARM       1
`define TTC_CMD_SOFT         2
`define TTC_CMD_CLR          3
`define TTC_CFG_SRC_LSB      0
`define TTC_CFG_SRC_MSB      2
`define TTC_CFG_FP_FALL      4
`define TTC_CFG_FS_FALL      5
`define TTC_ST_ARMED         0
`define TTC_ST_CAPT          1
`define TTC_ST_SRC_LSB       4
`define TTC_ST_SRC_MSB       6

`endif

// ===== rtl/ttc_pkg.sv
// types shared by the trigger time capture block
`include "ttc_cfg.svh"
package ttc_pkg;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TTC_DISARMED = 2'h0,
        TTC_ARMED    = 2'h1,
        TTC_FIRED    = 2'h3
    } ttc_state_t;

    typedef enum logic [2:0] {
        TTC_SRC_FRONT = 3'h0,
        TTC_SRC_FRAME = 3'h1,
        TTC_SRC_STAR  = 3'h2,
        TTC_SRC_MLVDS = 3'h3,
        TTC_SRC_SOFT  = 3'h4
    } ttc_src_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`TTC_AW-1:0] addr;
        logic [31:0]        wdata;
        logic               wr;
        logic               rd;
    } ttc_bus_t;

    typedef struct packed {
        logic                  pulse;
        ttc_src_t              source;
        logic                  fine_valid;
        logic [`TTC_TS_W-1:0]  ts;
        logic signed [31:0]    rstart;
    } ttc_event_t;

endpackage

// ===== rtl/ttc_fine_edge.sv
// first-edge locator over one word of trigger-clock samples
`timescale 1ns/10ps
`include "ttc_cfg.svh"
module ttc_fine_edge (
    input  wire logic [`TTC_FP_W-1:0]   sample_word,
    input  wire logic                   prev_bit,
    input  wire logic                   falling,
    output logic                        edge_found,
    output logic [`TTC_FINE_W-1:0]      edge_index
);

    // ------------------------------------------------------------------
    // per-step edge detection
    // ------------------------------------------------------------------
    logic [`TTC_FP_W-1:0] lvl;
    logic [`TTC_FP_W-1:0] hit;

    genvar gi;
    generate
        for (gi = 0; gi < `TTC_FP_W; gi = gi + 1) begin : g_step
            assign lvl[gi] = sample_word[gi] ^ falling;
            if (gi == 0) begin : g_first
                assign hit[gi] = lvl[gi] & ~(prev_bit ^ falling);
            end else begin : g_rest
                assign hit[gi] = lvl[gi] & ~lvl[gi-1];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // earliest edge wins; later edges in the word are dropped
    // ------------------------------------------------------------------
    always_comb begin
        edge_found = 1'b0;
        edge_index = '0;
        for (int i = `TTC_FP_W - 1; i >= 0; i--) begin
            if (hit[i]) begin
                edge_found = 1'b1;
                edge_index = `TTC_FINE_W'(i);
            end
        end
    end

endmodule

// ===== tb/ttc_front_panel_trigger_input_src.sv
// far-side trigger source model driving the sample words
`timescale 1ns/10ps
`include "ttc_cfg.svh"
module ttc_front_panel_trigger_input_src (
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire logic                 go,
    input  wire ttc_pkg::ttc_src_t    src,
    input  wire logic [5:0]           pos,
    input  wire logic                 fp_inv,
    input  wire logic                 fs_inv,
    output logic [`TTC_FP_W-1:0]      front,
    output logic [`TTC_CO_W-1:0]      frame,
    output logic [`TTC_CO_W-1:0]      star,
    output logic [`TTC_CO_W-1:0]      mlvds
);
    // ----
    // pulse state
    // ----
    logic [2:0]        left;
    ttc_pkg::ttc_src_t cur;
    logic [5:0]        at;
    logic [63:0]       w64;
    logic [1:0]        w2;

    // four words long, so the trailing edge reaches the block as well
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            left <= 3'h0;
            cur  <= ttc_pkg::TTC_SRC_FRONT;
            at   <= 6'h0;
        end else if (go) begin
            left <= 3'h4;
            cur  <= src;
            at   <= pos;
        end else if (left != 3'h0) begin
            left <= left - 3'h1;
        end
    end

    always_comb begin
        w64 = (left == 3'h4) ? ({64{1'b1}} << at) : {64{left != 3'h0}};
        w2 = (left == 3'h4) ? (2'h3 << at[0]) : {2{left != 3'h0}};
        front = ((cur == ttc_pkg::TTC_SRC_FRONT) ? w64 : 64'h0) ^ {64{fp_inv}};
        frame = ((cur == ttc_pkg::TTC_SRC_FRAME) ? w2 : 2'h0) ^ {2{fs_inv}};
        star = (cur == ttc_pkg::TTC_SRC_STAR) ? w2 : 2'h0;
        mlvds = (cur == ttc_pkg::TTC_SRC_MLVDS) ? w2 : 2'h0;
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the trigger time capture block
`timescale 1ns/10ps
`include "ttc_cfg.svh"
module tb_top;
    // ----
    // signals
    // ----
    logic                  clock;
    logic                  rst_b;
    ttc_pkg::ttc_bus_t     bus;
    logic [31:0]           rdata;
    logic [63:0]           front;
    logic [1:0]            frame;
    logic [1:0]            star;
    logic [1:0]            mlvds;
    ttc_pkg::ttc_event_t   front_panel_trigger_input_event;
    logic                  armed;
    logic                  go;
    ttc_pkg::ttc_src_t     src;
    logic [5:0]            pos;
    logic                  fp_inv;
    logic                  fs_inv;
    int                    mismatches;
    int                    n_compared;

    ttc_top ttc_top_inst (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .front_panel_trigger_input(front), .frame_sync_input(frame),
        .backplane_star_trigger(star), .backplane_mlvds_trigger(mlvds),
        .front_panel_trigger_input_event(front_panel_trigger_input_event), .armed(armed));
    ttc_front_panel_trigger_input_src ttc_front_panel_trigger_input_src_inst (.clock(clock), .rst_b(rst_b), .go(go), .src(src),
        .pos(pos), .fp_inv(fp_inv), .fs_inv(fs_inv), .front(front), .frame(frame),
        .star(star), .mlvds(mlvds));

    always #4 clock = ~clock;

    // ----
    // shared tasks
    // ----
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    task automatic fire(input ttc_pkg::ttc_src_t s, input logic [5:0] p);
        @(posedge clock);
        go <= 1'b1;
        src <= s;
        pos <= p;
        @(posedge clock);
        go <= 1'b0;
        #1;
    endtask

    // bounded: an event that never comes ends the run
    task automatic expect_evt(input int lat_e, input logic [2:0] s, input logic fv,
                              input logic [5:0] f, input int rs);
        int lat;
        lat = 0;
        while (front_panel_trigger_input_event.pulse !== 1'b1) begin
            if (lat == 10) begin
                mismatches++;
                stop_test();
            end
            @(posedge clock);
            #1;
            lat++;
        end
        check(lat, lat_e);
        check(front_panel_trigger_input_event.source, s);
        check(front_panel_trigger_input_event.fine_valid, fv);
        check(front_panel_trigger_input_event.ts[5:0], f);
        check(front_panel_trigger_input_event.rstart[31:0], rs[31:0]);
        @(posedge clock);
        #1;
        check(front_panel_trigger_input_event.pulse, 1'b0);
    endtask

    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (front_panel_trigger_input_event.pulse === 1'b1) begin
                hits++;
            end
        end
        check(hits, 0);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset();
        logic [7:0] regs [8] = '{`TTC_REG_CMD, `TTC_REG_CFG, `TTC_REG_DELAY, `TTC_REG_STATUS,
                                 `TTC_REG_TS_LO, `TTC_REG_TS_HI, `TTC_REG_RSTART, 8'h1c};
        check(armed, 1'b0);
        check(front_panel_trigger_input_event.ts, 48'h0);
        bus_wr(`TTC_REG_STATUS, 32'hffff_ffff);
        foreach (regs[i]) begin
            rd_chk(regs[i], 32'h0);
        end
    endtask

    task automatic t_disarmed();
        fire(ttc_pkg::TTC_SRC_FRONT, 6'h05);
        quiet(8);
        bus_wr(`TTC_REG_CMD, 32'h4);
        quiet(4);
    endtask

    task automatic t_front();
        logic [5:0] p [6] = '{6'd0, 6'd5, 6'd31, 6'd32, 6'd40, 6'd63};
        bus_wr(`TTC_REG_CMD, 32'h1);
        check(armed, 1'b1);
        foreach (p[i]) begin
            fire(ttc_pkg::TTC_SRC_FRONT, p[i]);
            expect_evt(1, 3'h0, 1'b1, p[i], (8 - p[i] % 8) % 8);
            quiet(6);
        end
        rd_chk(`TTC_REG_RSTART, 32'h1);
    endtask

    task automatic t_delay();
        bus_wr(`TTC_REG_DELAY, 32'd5000);
        fire(ttc_pkg::TTC_SRC_FRONT, 6'd3);
        expect_evt(1, 3'h0, 1'b1, 6'd3, 5005);
        quiet(6);
        bus_wr(`TTC_REG_DELAY, 32'hffff_ffec);
        fire(ttc_pkg::TTC_SRC_FRONT, 6'd9);
        expect_evt(1, 3'h0, 1'b1, 6'd9, -13);
        quiet(6);
        rd_chk(`TTC_REG_RSTART, 32'hffff_fff3);
        rd_chk(`TTC_REG_DELAY, 32'hffff_ffec);
        bus_wr(`TTC_REG_DELAY, 32'h0);
    endtask

    // polarity flips only where the new level is not the selected edge
    task automatic t_fall();
        bus_wr(`TTC_REG_CFG, 32'h10);
        @(posedge clock);
        fp_inv <= 1'b1;
        quiet(4);
        fire(ttc_pkg::TTC_SRC_FRONT, 6'd12);
        expect_evt(1, 3'h0, 1'b1, 6'd12, 4);
        quiet(6);
        bus_wr(`TTC_REG_CFG, 32'h0);
        @(posedge clock);
        fp_inv <= 1'b0;
        quiet(4);
    endtask

    task automatic t_coarse();
        ttc_pkg::ttc_src_t s [3] = '{ttc_pkg::TTC_SRC_FRAME, ttc_pkg::TTC_SRC_STAR,
                                     ttc_pkg::TTC_SRC_MLVDS};
        foreach (s[i]) begin
            bus_wr(`TTC_REG_CFG, {29'h0, s[i]});
            fire(ttc_pkg::TTC_SRC_FRONT, 6'd7);
            quiet(8);
            fire(s[i], {5'h0, i[0]});
            expect_evt(1, s[i], 1'b0, {i[0], 5'h0}, 0);
            quiet(6);
        end
        bus_wr(`TTC_REG_CFG, 32'h21);
        @(posedge clock);
        fs_inv <= 1'b1;
        quiet(4);
        fire(ttc_pkg::TTC_SRC_FRAME, 6'd1);
        expect_evt(1, 3'h1, 1'b0, 6'h20, 0);
        quiet(6);
    endtask

    task automatic t_soft();
        logic [47:0] ts0;
        bus_wr(`TTC_REG_CMD, 32'h2);
        check(armed, 1'b0);
        bus_wr(`TTC_REG_CFG, 32'h4);
        bus_wr(`TTC_REG_CMD, 32'h1);
        check(armed, 1'b1);
        @(posedge clock);
        bus <= '{addr: `TTC_REG_CMD, wdata: 32'h4, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        #1;
        check(front_panel_trigger_input_event.pulse, 1'b1);
        check(front_panel_trigger_input_event.source, 3'h4);
        check(front_panel_trigger_input_event.ts[5:0], 6'h0);
        ts0 = front_panel_trigger_input_event.ts;
        @(posedge clock);
        bus.wr <= 1'b0;
        #1;
        check(front_panel_trigger_input_event.pulse, 1'b1);
        check(front_panel_trigger_input_event.ts, ts0 + 48'h40);
        rd_chk(`TTC_REG_STATUS, 32'h43);
        bus_wr(`TTC_REG_DELAY, 32'd50);
        bus_wr(`TTC_REG_CMD, 32'h4);
        expect_evt(0, 3'h4, 1'b0, 6'h0, 50);
        // soft trigger and clear together: the capture must survive
        bus_wr(`TTC_REG_CMD, 32'hc);
        rd_chk(`TTC_REG_STATUS, 32'h43);
        bus_wr(`TTC_REG_CMD, 32'h8);
        rd_chk(`TTC_REG_STATUS, 32'h41);
    endtask

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        bus = '0;
        go = 1'b0;
        src = ttc_pkg::TTC_SRC_FRONT;
        pos = 6'h0;
        fp_inv = 1'b0;
        fs_inv = 1'b0;
        mismatches = 0;
        n_compared = 0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        t_reset();
        t_disarmed();
        t_front();
        t_delay();
        t_fall();
        t_coarse();
        t_soft();
        stop_test();
    end
endmodule
